// *** design/lps_defines.svh ***
`ifndef LPS_DEFINES_SVH
`define LPS_DEFINES_SVH
`define LPS_CLK_PERIOD_NS 50
`define LPS_RST_HOLD_NS 5000
`define LPS_RST_HOLD_CYC \
  ((`LPS_RST_HOLD_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)
`define LPS_STAB_MS 5
`define LPS_STAB_CYC (`LPS_STAB_MS * 1000000 / `LPS_CLK_PERIOD_NS)
`define LPS_BOOST_MS 40
`define LPS_BOOST_CYC (`LPS_BOOST_MS * 1000000 / `LPS_CLK_PERIOD_NS)
`define LPS_NEG_IGN_NS 500
`define LPS_NEG_IGN_CYC (`LPS_NEG_IGN_NS / `LPS_CLK_PERIOD_NS)
`define LPS_POS_IGN_NS 10
`define LPS_POS_IGN_CYC \
  ((`LPS_POS_IGN_NS / `LPS_CLK_PERIOD_NS) < 1 ? 1 : \
   (`LPS_POS_IGN_NS / `LPS_CLK_PERIOD_NS))
`define LPS_CMD_SWRESET 8'h01
`define LPS_CMD_BOOST_ON 8'h03
`define LPS_CMD_SLEEP_IN 8'h10
`define LPS_CMD_SLEEP_OUT 8'h11
`define LPS_CMD_CONTRAST 8'h25
`define LPS_CMD_DISP_OFF 8'h28
`define LPS_CMD_DISP_ON 8'h29
`define LPS_CMD_GRAY_A 8'hB3
`define LPS_CMD_GRAY_B 8'hB4
`define LPS_CMD_GAMMA 8'hB5
`define LPS_CMD_DISP_CTRL 8'hB6
`define LPS_CMD_TEMP_GRAD 8'hB7
`define LPS_CMD_STATE_SET 8'hB9
`define LPS_CMD_VOLT_CTRL 8'hBA
`define LPS_CMD_COM_SEL 8'hBD
`define LPS_CMD_PWR_CTRL 8'hBE
`define LPS_CMD_INIT 8'hC6
`define LPS_SEEN_W 11
`endif

// *** design/lps_pkg.sv ***
package lps_pkg;
  typedef enum logic [3:0] {
    H_IDLE     = 4'h0,
    H_RST_LOW  = 4'h1,
    H_RST_WAIT = 4'h2,
    H_LOAD     = 4'h3,
    H_PARAM    = 4'h4,
    H_AFTER    = 4'h5,
    H_WAIT     = 4'h6,
    H_UP       = 4'h7,
    H_OFF      = 4'h8
  } lps_host_e;
  typedef logic [7:0] lps_byte_t;
  typedef logic [4:0] lps_idx_t;
endpackage : lps_pkg

// *** design/lps_link_if.sv ***
`timescale 1ns/1ps
interface lps_link_if;
  logic             hw_reset_n_pin;
  logic             wr_stb;
  logic             dc;
  lps_pkg::lps_byte_t data;
  modport host (
    output hw_reset_n_pin,
    output wr_stb,
    output dc,
    output data
  );
  modport dev (
    input hw_reset_n_pin,
    input wr_stb,
    input dc,
    input data
  );
endinterface : lps_link_if

// *** design/lps_device.sv ***
`timescale 1ns/1ps
`include "lps_defines.svh"
module lps_device (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  lps_link_if.dev                 link,
  output logic                    in_reset,
  output logic                    sw_reset_seen,
  output logic                    init_done,
  output logic [`LPS_SEEN_W-1:0]  setup_seen,
  output logic                    osc_run,
  output logic                    booster_run,
  output logic                    display_on,
  output logic                    cmd_stb,
  output lps_pkg::lps_byte_t      cmd_code,
  output logic                    param_stb,
  output lps_pkg::lps_byte_t      param_data,
  output logic [3:0]              param_idx
);
  logic [2:0] pin_sync;
  logic [3:0] flt_cnt;
  logic [3:0] next_flt_cnt;
  logic       next_in_reset;
  logic       next_sw_reset_seen;
  logic       next_init_done;
  logic [`LPS_SEEN_W-1:0] next_setup_seen;
  logic       next_osc_run;
  logic       next_booster_run;
  logic       next_display_on;
  logic       next_cmd_stb;
  lps_pkg::lps_byte_t next_cmd_code;
  logic       next_param_stb;
  lps_pkg::lps_byte_t next_param_data;
  logic [3:0] next_param_idx;
  logic       agree;
  logic       lvl;

  assign agree = pin_sync[1] == pin_sync[2];
  assign lvl   = pin_sync[2];

  // The filter counts consecutive agreed samples of the opposite level, so
  // short glitches restart the count and never change the reset state.
  always_comb begin
    next_in_reset = in_reset;
    next_flt_cnt  = 4'h0;
    if (agree && in_reset && lvl) begin
      next_flt_cnt = flt_cnt + 4'h1;
      if (flt_cnt >= 4'(`LPS_POS_IGN_CYC)) begin
        next_in_reset = 1'b0;
        next_flt_cnt  = 4'h0;
      end
    end else if (agree && !in_reset && !lvl) begin
      next_flt_cnt = flt_cnt + 4'h1;
      if (flt_cnt >= 4'(`LPS_NEG_IGN_CYC)) begin
        next_in_reset = 1'b1;
        next_flt_cnt  = 4'h0;
      end
    end
  end

  always_comb begin
    next_sw_reset_seen = sw_reset_seen;
    next_init_done     = init_done;
    next_setup_seen    = setup_seen;
    next_osc_run       = osc_run;
    next_booster_run   = booster_run;
    next_display_on    = display_on;
    next_cmd_stb       = 1'b0;
    next_cmd_code      = cmd_code;
    next_param_stb     = 1'b0;
    next_param_data    = param_data;
    next_param_idx     = param_idx;
    if (in_reset) begin
      next_sw_reset_seen = 1'b0;
      next_init_done     = 1'b0;
      next_setup_seen    = '0;
      next_osc_run       = 1'b0;
      next_booster_run   = 1'b0;
      next_display_on    = 1'b0;
      next_cmd_code      = 8'h00;
      next_param_idx     = 4'h0;
    end else if (link.wr_stb && link.dc) begin
      next_param_stb  = 1'b1;
      next_param_data = link.data;
      next_param_idx  = param_idx + 4'h1;
    end else if (link.wr_stb) begin
      next_cmd_stb   = 1'b1;
      next_cmd_code  = link.data;
      next_param_idx = 4'h0;
      unique case (link.data)
        `LPS_CMD_SWRESET: begin
          next_sw_reset_seen = 1'b1;
          next_init_done     = 1'b0;
          next_setup_seen    = '0;
          next_osc_run       = 1'b0;
          next_booster_run   = 1'b0;
          next_display_on    = 1'b0;
        end
        `LPS_CMD_INIT:      next_init_done = 1'b1;
        `LPS_CMD_STATE_SET: next_setup_seen[0] = 1'b1;
        `LPS_CMD_DISP_CTRL: next_setup_seen[1] = 1'b1;
        `LPS_CMD_GRAY_A:    next_setup_seen[2] = 1'b1;
        `LPS_CMD_GRAY_B:    next_setup_seen[3] = 1'b1;
        `LPS_CMD_GAMMA:     next_setup_seen[4] = 1'b1;
        `LPS_CMD_COM_SEL:   next_setup_seen[5] = 1'b1;
        `LPS_CMD_PWR_CTRL:  next_setup_seen[6] = 1'b1;
        `LPS_CMD_VOLT_CTRL: next_setup_seen[7] = 1'b1;
        `LPS_CMD_CONTRAST:  next_setup_seen[8] = 1'b1;
        `LPS_CMD_TEMP_GRAD: next_setup_seen[9] = 1'b1;
        `LPS_CMD_SLEEP_OUT: next_osc_run = 1'b1;
        `LPS_CMD_BOOST_ON: begin
          next_booster_run    = 1'b1;
          next_setup_seen[10] = 1'b1;
        end
        `LPS_CMD_DISP_ON:  next_display_on = 1'b1;
        `LPS_CMD_DISP_OFF: next_display_on = 1'b0;
        `LPS_CMD_SLEEP_IN: begin
          next_osc_run     = 1'b0;
          next_booster_run = 1'b0;
          next_display_on  = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_sync      <= 3'h0;
      flt_cnt       <= 4'h0;
      in_reset      <= 1'b1;
      sw_reset_seen <= 1'b0;
      init_done     <= 1'b0;
      setup_seen    <= '0;
      osc_run       <= 1'b0;
      booster_run   <= 1'b0;
      display_on    <= 1'b0;
      cmd_stb       <= 1'b0;
      cmd_code      <= 8'h00;
      param_stb     <= 1'b0;
      param_data    <= 8'h00;
      param_idx     <= 4'h0;
    end else begin
      pin_sync      <= {pin_sync[1:0], link.hw_reset_n_pin};
      flt_cnt       <= next_flt_cnt;
      in_reset      <= next_in_reset;
      sw_reset_seen <= next_sw_reset_seen;
      init_done     <= next_init_done;
      setup_seen    <= next_setup_seen;
      osc_run       <= next_osc_run;
      booster_run   <= next_booster_run;
      display_on    <= next_display_on;
      cmd_stb       <= next_cmd_stb;
      cmd_code      <= next_cmd_code;
      param_stb     <= next_param_stb;
      param_data    <= next_param_data;
      param_idx     <= next_param_idx;
    end
  end
endmodule : lps_device

// *** design/lps_host.sv ***
`timescale 1ns/1ps
`include "lps_defines.svh"
module lps_host #(
  parameter int unsigned STAB_CYC  = `LPS_STAB_CYC,
  parameter int unsigned BOOST_CYC = `LPS_BOOST_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  lps_link_if.host                link,
  input  wire logic               start,
  input  wire logic               power_down,
  input  wire logic [15:0]        skip_mask,
  input  wire logic               param_valid,
  input  wire logic               param_last,
  input  wire logic               param_none,
  input  wire lps_pkg::lps_byte_t param_data,
  output logic                    param_req,
  output lps_pkg::lps_byte_t      cur_cmd,
  output logic                    busy,
  output logic                    powered_up,
  output logic                    powered_off
);
  localparam logic [19:0] HOLD_LIM  = 20'(`LPS_RST_HOLD_CYC - 1);
  localparam logic [19:0] STAB_LIM  = 20'(STAB_CYC - 1);
  localparam logic [19:0] BOOST_LIM = 20'(BOOST_CYC - 1);
  localparam lps_pkg::lps_idx_t IDX_SWRESET = 5'h00;
  localparam lps_pkg::lps_idx_t IDX_BOOST   = 5'h0D;
  localparam lps_pkg::lps_idx_t IDX_DISP_ON = 5'h0E;
  localparam lps_pkg::lps_idx_t IDX_PD      = 5'h0F;
  localparam lps_pkg::lps_idx_t IDX_LAST    = 5'h10;

  lps_pkg::lps_host_e state;
  lps_pkg::lps_host_e next_state;
  lps_pkg::lps_idx_t  idx;
  lps_pkg::lps_idx_t  next_idx;
  logic [19:0]        timer;
  logic [19:0]        next_timer;
  logic [19:0]        wait_lim;
  logic [19:0]        next_wait_lim;
  logic               pin;
  logic               next_pin;
  logic               wr;
  logic               next_wr;
  logic               dc;
  logic               next_dc;
  lps_pkg::lps_byte_t data;
  lps_pkg::lps_byte_t next_data;
  lps_pkg::lps_byte_t seq_code;
  logic               skippable;

  // The power-up list runs in the required order; the display setup
  // group is fixed here although the device accepts it in any order.
  always_comb begin
    unique case (idx)
      5'h00: seq_code = `LPS_CMD_SWRESET;
      5'h01: seq_code = `LPS_CMD_INIT;
      5'h02: seq_code = `LPS_CMD_STATE_SET;
      5'h03: seq_code = `LPS_CMD_DISP_CTRL;
      5'h04: seq_code = `LPS_CMD_GRAY_A;
      5'h05: seq_code = `LPS_CMD_GRAY_B;
      5'h06: seq_code = `LPS_CMD_GAMMA;
      5'h07: seq_code = `LPS_CMD_COM_SEL;
      5'h08: seq_code = `LPS_CMD_PWR_CTRL;
      5'h09: seq_code = `LPS_CMD_SLEEP_OUT;
      5'h0A: seq_code = `LPS_CMD_VOLT_CTRL;
      5'h0B: seq_code = `LPS_CMD_CONTRAST;
      5'h0C: seq_code = `LPS_CMD_TEMP_GRAD;
      5'h0D: seq_code = `LPS_CMD_BOOST_ON;
      5'h0E: seq_code = `LPS_CMD_DISP_ON;
      5'h0F: seq_code = `LPS_CMD_DISP_OFF;
      5'h10: seq_code = `LPS_CMD_SLEEP_IN;
      default: seq_code = 8'h00;
    endcase
  end

  // Reset, init, sleep-out, booster and display commands are never
  // skipped because their effect is needed on every power-up.
  assign skippable = (idx >= 5'h02) && (idx <= 5'h0C) && (idx != 5'h09);

  always_comb begin
    next_state    = state;
    next_idx      = idx;
    next_timer    = timer;
    next_wait_lim = wait_lim;
    next_pin      = pin;
    next_wr       = 1'b0;
    next_dc       = dc;
    next_data     = data;
    unique case (state)
      lps_pkg::H_IDLE: begin
        next_pin = 1'b0;
        if (start) begin
          next_state = lps_pkg::H_RST_LOW;
          next_timer = 20'h00000;
        end
      end
      lps_pkg::H_RST_LOW: begin
        next_pin   = 1'b0;
        next_timer = timer + 20'h00001;
        if (timer >= HOLD_LIM) begin
          next_pin   = 1'b1;
          next_timer = 20'h00000;
          next_state = lps_pkg::H_RST_WAIT;
        end
      end
      lps_pkg::H_RST_WAIT: begin
        next_timer = timer + 20'h00001;
        if (timer >= STAB_LIM) begin
          next_idx   = IDX_SWRESET;
          next_state = lps_pkg::H_LOAD;
        end
      end
      lps_pkg::H_LOAD: begin
        if (skippable && skip_mask[idx[3:0]]) begin
          next_idx = idx + 5'h01;
        end else begin
          next_wr    = 1'b1;
          next_dc    = 1'b0;
          next_data  = seq_code;
          next_state = lps_pkg::H_PARAM;
        end
      end
      lps_pkg::H_PARAM: begin
        if (param_none) begin
          next_state = lps_pkg::H_AFTER;
        end else if (param_valid) begin
          next_wr   = 1'b1;
          next_dc   = 1'b1;
          next_data = param_data;
          if (param_last) begin
            next_state = lps_pkg::H_AFTER;
          end
        end
      end
      lps_pkg::H_AFTER: begin
        next_timer = 20'h00000;
        if (idx == IDX_SWRESET) begin
          next_wait_lim = STAB_LIM;
          next_state    = lps_pkg::H_WAIT;
        end else if (idx == IDX_BOOST) begin
          next_wait_lim = BOOST_LIM;
          next_state    = lps_pkg::H_WAIT;
        end else if (idx == IDX_DISP_ON) begin
          next_state = lps_pkg::H_UP;
        end else if (idx == IDX_LAST) begin
          next_state = lps_pkg::H_OFF;
        end else begin
          next_idx   = idx + 5'h01;
          next_state = lps_pkg::H_LOAD;
        end
      end
      lps_pkg::H_WAIT: begin
        next_timer = timer + 20'h00001;
        if (timer >= wait_lim) begin
          next_idx   = idx + 5'h01;
          next_state = lps_pkg::H_LOAD;
        end
      end
      lps_pkg::H_UP: begin
        if (power_down) begin
          next_idx   = IDX_PD;
          next_state = lps_pkg::H_LOAD;
        end
      end
      lps_pkg::H_OFF: begin
        if (start) begin
          next_pin   = 1'b0;
          next_timer = 20'h00000;
          next_state = lps_pkg::H_RST_LOW;
        end
      end
      default: begin
        next_state = lps_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state    <= lps_pkg::H_IDLE;
      idx      <= 5'h00;
      timer    <= 20'h00000;
      wait_lim <= 20'h00000;
      pin      <= 1'b0;
      wr       <= 1'b0;
      dc       <= 1'b0;
      data     <= 8'h00;
    end else begin
      state    <= next_state;
      idx      <= next_idx;
      timer    <= next_timer;
      wait_lim <= next_wait_lim;
      pin      <= next_pin;
      wr       <= next_wr;
      dc       <= next_dc;
      data     <= next_data;
    end
  end

  assign link.hw_reset_n_pin = pin;
  assign link.wr_stb         = wr;
  assign link.dc             = dc;
  assign link.data           = data;
  assign param_req   = state == lps_pkg::H_PARAM;
  assign cur_cmd     = seq_code;
  assign busy        = (state != lps_pkg::H_IDLE) &&
                       (state != lps_pkg::H_UP) &&
                       (state != lps_pkg::H_OFF);
  assign powered_up  = state == lps_pkg::H_UP;
  assign powered_off = state == lps_pkg::H_OFF;
endmodule : lps_host

// *** tb/lps_link_properties.sv ***
`timescale 1ns/1ps
module lps_link_properties #(
  parameter int unsigned STAB_CYC  = 20,
  parameter int unsigned BOOST_CYC = 40
) (
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic               hw_reset_n_pin,
  input wire logic               wr_stb,
  input wire logic               dc,
  input wire lps_pkg::lps_byte_t data
);
  logic [10:0]        low_cnt;
  logic [10:0]        high_cnt;
  logic [10:0]        gap;
  lps_pkg::lps_byte_t last_cmd;
  logic               first;
  logic               cmd_w;
  assign cmd_w = wr_stb && !dc;
  // Counters saturate so a long idle stretch cannot wrap into a pass.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      low_cnt <= '0;
      high_cnt <= '0;
      gap <= '0;
      last_cmd <= '0;
      first <= 1'b1;
    end else begin
      low_cnt <= hw_reset_n_pin ? '0 : low_cnt + {10'h000, ~&low_cnt};
      high_cnt <= !hw_reset_n_pin ? '0 : high_cnt + {10'h000, ~&high_cnt};
      gap <= cmd_w ? '0 : gap + {10'h000, ~&gap};
      last_cmd <= cmd_w ? data : last_cmd;
      first <= !hw_reset_n_pin ? 1'b1 : (cmd_w ? 1'b0 : first);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rst_quiet;
    disable iff (1'b0) !rst_n |=> !hw_reset_n_pin && !wr_stb;
  endproperty
  property p_hold;
    $rose(hw_reset_n_pin) |-> low_cnt >= 11'h064;
  endproperty
  property p_no_wr_low;
    wr_stb |-> hw_reset_n_pin;
  endproperty
  property p_stab;
    wr_stb |-> high_cnt >= STAB_CYC;
  endproperty
  property p_swr_first;
    cmd_w && first |-> data == 8'h01;
  endproperty
  property p_init_next;
    cmd_w && last_cmd == 8'h01 |-> data == 8'hC6 && gap >= STAB_CYC;
  endproperty
  property p_after_osc;
    cmd_w && last_cmd == 8'h11 |-> data inside {8'hBA, 8'h25, 8'hB7, 8'h03};
  endproperty
  property p_boost_last;
    cmd_w && data == 8'h03 |-> last_cmd inside {8'h11, 8'hBA, 8'h25, 8'hB7};
  endproperty
  property p_boost_wait;
    cmd_w && last_cmd == 8'h03 |-> data == 8'h29 && gap >= BOOST_CYC;
  endproperty
  property p_pd_order;
    cmd_w && last_cmd == 8'h28 |-> data == 8'h10;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("link not quiet in reset");
  a_hold: assert property (p_hold)
    else $error("reset pin released too early");
  a_no_wr_low: assert property (p_no_wr_low)
    else $error("write while reset pin low");
  a_stab: assert property (p_stab)
    else $error("write before stabilizing wait");
  a_swr_first: assert property (p_swr_first)
    else $error("first command not software reset");
  a_init_next: assert property (p_init_next)
    else $error("initialize command wrong or early");
  a_after_osc: assert property (p_after_osc)
    else $error("wrong command after sleep out");
  a_boost_last: assert property (p_boost_last)
    else $error("booster on out of order");
  a_boost_wait: assert property (p_boost_wait)
    else $error("display on wrong or early");
  a_pd_order: assert property (p_pd_order)
    else $error("sleep in does not follow display off");
  c_rise: cover property ($rose(hw_reset_n_pin));
  c_disp_on: cover property (cmd_w && data == 8'h29);
  c_sleep_in: cover property (cmd_w && data == 8'h10);
endmodule : lps_link_properties

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic               ref_clk     = 1'b0;
  logic               rst_n       = 1'b0;
  logic               start       = 1'b0;
  logic               power_down  = 1'b0;
  logic [15:0]        skip_mask   = 16'h0000;
  logic               param_valid = 1'b0;
  logic               param_last  = 1'b0;
  logic               param_none  = 1'b0;
  lps_pkg::lps_byte_t param_data  = 8'h00;
  logic               param_req, powered_up, powered_off, in_reset;
  logic               sw_reset_seen, init_done, osc_run, booster_run;
  logic               display_on, cmd_stb, param_stb;
  logic               g_in_reset, g_cmd_stb, g_swr, g_osc, busy;
  logic [10:0]        setup_seen;
  logic [3:0]         param_idx;
  lps_pkg::lps_byte_t cmd_code, dev_pdata, g_cmd_code, p_data, host_cmd;
  logic               p_wr = 1'b0;
  logic               p_dc = 1'b0;
  logic               ended = 1'b0;
  logic [31:0]        rnd = 32'h00014925;
  logic [3:0]         pcnt = 4'h0;
  int                 cidx, pn, run, cycles, bad_count, checks_done;
  lps_pkg::lps_byte_t q [$];
  lps_pkg::lps_byte_t exp_list [0:16] = '{8'h01, 8'hC6, 8'hB9, 8'hB6,
    8'hB3, 8'hB4, 8'hB5, 8'hBD, 8'hBE, 8'h11, 8'hBA, 8'h25, 8'hB7,
    8'h03, 8'h29, 8'h28, 8'h10};
  lps_link_if link();
  lps_link_if link_b();
  always #25 ref_clk = ~ref_clk;
  lps_host #(.STAB_CYC(20), .BOOST_CYC(40)) lps_host_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(link), .start(start), .power_down(power_down),
    .skip_mask(skip_mask), .param_valid(param_valid),
    .param_last(param_last), .param_none(param_none),
    .param_data(param_data), .param_req(param_req), .cur_cmd(host_cmd),
    .busy(busy), .powered_up(powered_up), .powered_off(powered_off));
  lps_device lps_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .in_reset(in_reset), .sw_reset_seen(sw_reset_seen),
    .init_done(init_done), .setup_seen(setup_seen), .osc_run(osc_run),
    .booster_run(booster_run), .display_on(display_on),
    .cmd_stb(cmd_stb), .cmd_code(cmd_code), .param_stb(param_stb),
    .param_data(dev_pdata), .param_idx(param_idx));
  // Second device is driven directly so the pin can be glitched.
  lps_device glitch_lps_device_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link_b), .in_reset(g_in_reset), .sw_reset_seen(g_swr),
    .init_done(), .setup_seen(), .osc_run(g_osc), .booster_run(),
    .display_on(), .cmd_stb(g_cmd_stb), .cmd_code(g_cmd_code),
    .param_stb(), .param_data(), .param_idx());
  lps_link_properties #(.STAB_CYC(20), .BOOST_CYC(40)) props_i (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .hw_reset_n_pin(link.hw_reset_n_pin), .wr_stb(link.wr_stb),
    .dc(link.dc), .data(link.data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [10:0] exp_seen(input logic [15:0] m);
    return {1'b1, ~m[12:10], ~m[8:2]};
  endfunction : exp_seen
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic pin_b(input logic v, input int n);
    link_b.hw_reset_n_pin <= v;
    repeat (n) @(posedge ref_clk);
  endtask : pin_b
  // Called on a clock edge; the strobe stands for exactly one edge and the
  // answer is read one edge later, before that edge updates it.
  task automatic send_b(input lps_pkg::lps_byte_t d, input logic e);
    link_b.wr_stb <= 1'b1;
    link_b.data <= d;
    @(posedge ref_clk);
    link_b.wr_stb <= 1'b0;
    @(posedge ref_clk);
    chk(g_cmd_stb, e);
    if (e) chk(g_cmd_code, d);
  endtask : send_b
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      final_report();
    end
  end
  always @(posedge ref_clk) begin
    if (rst_n) begin
      chk({cmd_stb, param_stb}, {p_wr & ~p_dc, p_wr & p_dc});
      if (p_wr && !p_dc) chk(cmd_code, p_data);
      if (p_wr && p_dc) chk({dev_pdata, param_idx}, {p_data, pcnt});
    end
    if (link.wr_stb && !link.dc) begin
      while (cidx > 1 && cidx < 13 && cidx != 9 && skip_mask[cidx]) cidx++;
      chk(link.data, cidx < 17 ? exp_list[cidx] : 8'hFF);
      chk(host_cmd, cidx < 17 ? exp_list[cidx] : 8'hFF);
      cidx++;
      pcnt = 4'h0;
    end
    if (link.wr_stb && link.dc) begin
      pcnt++;
      if (q.size() == 0) chk(1'b1, 1'b0);
      else chk(link.data, q.pop_front());
    end
    p_wr = link.wr_stb;
    p_dc = link.dc;
    p_data = link.data;
  end
  // Random parameter source; a junk byte beside param_none must be dropped.
  always @(posedge ref_clk) begin
    param_valid <= 1'b0;
    param_last <= 1'b0;
    param_none <= 1'b0;
    if (param_req && !ended) begin
      rnd = lfsr(rnd);
      param_data <= rnd[15:8];
      if (rnd[1:0] == 2'h3 || pn >= 6) begin
        param_none <= 1'b1;
        param_valid <= rnd[2];
        ended = 1'b1;
        pn = 0;
      end else if (rnd[1:0] != 2'h0) begin
        param_valid <= 1'b1;
        param_last <= rnd[1];
        q.push_back(rnd[15:8]);
        pn++;
        ended = rnd[1];
        if (rnd[1]) pn = 0;
      end
    end else begin
      ended = 1'b0;
    end
  end
  initial begin
    link_b.hw_reset_n_pin = 1'b0;
    link_b.wr_stb = 1'b0;
    link_b.dc = 1'b0;
    link_b.data = 8'h00;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    pin_b(1'b1, 1);
    pin_b(1'b0, 8);
    chk(g_in_reset, 1'b1);
    pin_b(1'b1, 10);
    chk(g_in_reset, 1'b0);
    send_b(8'h11, 1'b1);
    chk(g_osc, 1'b1);
    send_b(8'h01, 1'b1);
    chk({g_swr, g_osc}, 2'h2);
    pin_b(1'b0, 10);
    pin_b(1'b1, 8);
    chk(g_in_reset, 1'b0);
    send_b(8'h03, 1'b1);
    pin_b(1'b0, 20);
    chk(g_in_reset, 1'b1);
    send_b(8'h29, 1'b0);
    for (run = 0; run < 3; run++) begin
      rnd = lfsr(rnd);
      skip_mask <= run == 0 ? rnd[15:0] : (run == 1 ? 16'hFFFF : 16'h0000);
      cidx = 0;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (30) @(posedge ref_clk);
      start <= 1'b1;
      power_down <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      power_down <= 1'b0;
      chk(busy, 1'b1);
      while (powered_up !== 1'b1) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      chk({sw_reset_seen, init_done, osc_run, booster_run, display_on,
           in_reset, busy}, 7'h7C);
      chk(setup_seen, exp_seen(skip_mask));
      power_down <= 1'b1;
      @(posedge ref_clk);
      power_down <= 1'b0;
      while (powered_off !== 1'b1) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      chk({osc_run, booster_run, display_on, busy}, 4'h0);
    end
    final_report();
  end
endmodule : testbench
